// ### rtl/asq_top.sv
// Scan sequencer: channel list, pacing clock, trigger and result FIFO.
// Assumes a converter on mclk that answers each start with one done.
// Function
// - List of one to eight scan entries
// - Entries in any order, duplicates allowed
// - List kept until host rewrites it
// - Two-bit range code per entry
// - Differential mode limits channels to four
// - Trigger edge or level, either polarity
// - Trigger resets to rising edge
// - Pacing clock internal or external pin
// - Internal scan clock echoed on output pin
// - Internal clock is 80 MHz over period
// - Over range returns full-scale code
// - Paced scan fills FIFO until stopped
// - Scan starts by command or trigger
// - Software command gives one conversion
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module asq_top (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [asq_pkg::ADDR_W-1:0] regAddr,
	input wire logic [asq_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [asq_pkg::DATA_W-1:0] regRdata,
	input wire logic ext_sample_clock_in,
	input wire logic ext_trigger_pin,
	output logic sample_clock_out,
	output logic convStart,
	output asq_pkg::asq_entry_t convReq,
	input wire logic convDone,
	input wire logic [asq_pkg::CODE_W-1:0] adcData,
	input wire logic adcOverHigh,
	input wire logic adcOverLow
);
	import asq_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ARMED,
		S_RUN,
		S_CONV,
		S_SWCONV
	} asq_state_t;

	// ==========================================================
	// Decode helpers
	function automatic logic isListAddr(input logic [ADDR_W-1:0] a);
		isListAddr = (a[ADDR_W-1:5] == ADDR_LIST[ADDR_W-1:5]);
	endfunction

	// Differential inputs only exist on channels 0 to 3
	function automatic asq_entry_t limitEntry(input asq_entry_t e);
		asq_entry_t r;
		r = e;
		if (e.mode == DIFFERENTIAL_MODE) begin
			r.chan[IDX_W-1] = 1'b0;
		end
		limitEntry = r;
	endfunction

	function automatic logic [31:0] clampPeriod(input logic [31:0] p);
		if (p < PERIOD_MIN) begin
			clampPeriod = PERIOD_MIN;
		end else if (p > PERIOD_MAX) begin
			clampPeriod = PERIOD_MAX;
		end else begin
			clampPeriod = p;
		end
	endfunction

	// ==========================================================
	// Registers
	asq_entry_t list_reg [LIST_DEPTH];
	logic [IDX_W-1:0] lastIdx_reg;
	logic [31:0] period_reg;
	logic extClkSel_reg;
	logic trigEn_reg;
	asq_ext_trigger_pin_t trigMode_reg;
	logic overrun_reg;
	logic swDone_reg;
	logic [CODE_W-1:0] swResult_reg;
	logic [DATA_W-1:0] rdata_reg;
	asq_state_t state_reg;
	asq_state_t state_next;
	logic [IDX_W-1:0] idx_reg;
	logic [32:0] divAcc_reg;
	logic sampleClkOut_reg;
	logic convStart_reg;
	asq_entry_t convReq_reg;

	logic wrCtrl;
	logic cmdStart;
	logic cmdStop;
	logic cmdSw;
	logic [31:0] periodEff;
	logic [32:0] divSum;
	logic intTick;
	logic tick;
	logic trigHit;
	logic [CODE_W-1:0] sampleCode;
	logic fifoInValid;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoPop;
	asq_sample_t fifoInData;
	asq_sample_t fifoOutData;
	logic [FIFO_CNT_W-1:0] fifoCount;

	assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
	assign cmdStart = wrCtrl && regWdata[CTRL_START];
	assign cmdStop = wrCtrl && regWdata[CTRL_STOP];
	assign cmdSw = wrCtrl && regWdata[CTRL_SWCONV];

	// ==========================================================
	// Configuration and scan list
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			extClkSel_reg <= 1'b0;
			trigEn_reg <= 1'b0;
			trigMode_reg <= EXT_TRIGGER_PIN_RISE;
		end else if (wrCtrl) begin
			extClkSel_reg <= regWdata[CTRL_EXTCLK];
			trigEn_reg <= regWdata[CTRL_TRIGEN];
			trigMode_reg <= asq_ext_trigger_pin_t'(regWdata[CTRL_TRIGMODE+:2]);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lastIdx_reg <= '0;
			period_reg <= PERIOD_MIN;
		end else if (regWr && regAddr == ADDR_LEN) begin
			lastIdx_reg <= regWdata[IDX_W-1:0];
		end else if (regWr && regAddr == ADDR_PERIOD) begin
			period_reg <= regWdata;
		end
	end

	// Entries stay until rewritten; order and duplicates are free
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int i = 0; i < LIST_DEPTH; i++) begin
				list_reg[i] <= '0;
			end
		end else if (regWr && isListAddr(regAddr)) begin
			list_reg[regAddr[4:2]] <= limitEntry(
				asq_entry_t'(regWdata[ENTRY_W-1:0]));
		end
	end

	// ==========================================================
	// Pacing clock
	// Two flops per pin; edges are taken from the second stage only
	logic [1:0] extClkSync_reg;
	logic extClkLast_reg;
	logic [1:0] trigSync_reg;
	logic trigLast_reg;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			extClkSync_reg <= '0;
			extClkLast_reg <= 1'b0;
			trigSync_reg <= '0;
			trigLast_reg <= 1'b0;
		end else begin
			extClkSync_reg <= {extClkSync_reg[0], ext_sample_clock_in};
			extClkLast_reg <= extClkSync_reg[1];
			trigSync_reg <= {trigSync_reg[0], ext_trigger_pin};
			trigLast_reg <= trigSync_reg[1];
		end
	end

	// Accumulator keeps the mean rate exact for odd periods,
	// at the cost of up to one cycle of jitter per tick
	assign periodEff = clampPeriod(period_reg);
	assign divSum = divAcc_reg + TB_PER_MCLK;
	assign intTick = (divSum >= {1'b0, periodEff});

	always_ff @(posedge mclk) begin
		if (sys_rst || state_reg == S_IDLE || state_reg == S_ARMED) begin
			divAcc_reg <= '0;
		end else if (intTick) begin
			divAcc_reg <= divSum - {1'b0, periodEff};
		end else begin
			divAcc_reg <= divSum;
		end
	end

	assign tick = extClkSel_reg ?
		(extClkSync_reg[1] && !extClkLast_reg) : intTick;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sampleClkOut_reg <= 1'b0;
		end else begin
			sampleClkOut_reg <= intTick && !extClkSel_reg &&
				(state_reg == S_RUN || state_reg == S_CONV);
		end
	end

	// ==========================================================
	// Trigger qualification
	always_comb begin
		unique case (trigMode_reg)
			EXT_TRIGGER_PIN_RISE: trigHit = trigSync_reg[1] && !trigLast_reg;
			EXT_TRIGGER_PIN_FALL: trigHit = !trigSync_reg[1] && trigLast_reg;
			EXT_TRIGGER_PIN_HIGH: trigHit = trigSync_reg[1];
			EXT_TRIGGER_PIN_LOW: trigHit = !trigSync_reg[1];
		endcase
	end

	// ==========================================================
	// Sequencer
	// A stop that lands while a conversion is out must not be lost
	logic stopPend_reg;

	always_ff @(posedge mclk) begin
		if (sys_rst || state_reg != S_CONV) begin
			stopPend_reg <= 1'b0;
		end else if (cmdStop) begin
			stopPend_reg <= 1'b1;
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE: begin
				if (cmdStart) begin
					// Enable bit travels in the same write as start
					state_next = regWdata[CTRL_TRIGEN] ?
						S_ARMED : S_RUN;
				end else if (cmdSw) begin
					state_next = S_SWCONV;
				end
			end
			S_ARMED: begin
				if (cmdStop) begin
					state_next = S_IDLE;
				end else if (trigHit) begin
					state_next = S_RUN;
				end
			end
			S_RUN: begin
				if (cmdStop) begin
					state_next = S_IDLE;
				end else if (tick && fifoInReady) begin
					state_next = S_CONV;
				end
			end
			S_CONV: begin
				if (convDone) begin
					state_next = (cmdStop || stopPend_reg) ?
						S_IDLE : S_RUN;
				end
			end
			S_SWCONV: begin
				if (convDone) begin
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// A stop during a conversion is honoured once its result is stored
	always_ff @(posedge mclk) begin
		if (sys_rst || (state_reg == S_IDLE && cmdStart)) begin
			idx_reg <= '0;
		end else if (state_reg == S_CONV && convDone) begin
			idx_reg <= (idx_reg == lastIdx_reg) ? '0 : idx_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			convStart_reg <= 1'b0;
			convReq_reg <= '0;
		end else begin
			convStart_reg <= (state_reg == S_RUN && state_next == S_CONV) ||
				(state_reg == S_IDLE && state_next == S_SWCONV);
			if (state_reg == S_IDLE) begin
				convReq_reg <= list_reg[0];
			end else if (state_reg == S_RUN) begin
				convReq_reg <= list_reg[idx_reg];
			end
		end
	end

	assign convStart = convStart_reg;
	assign convReq = convReq_reg;

	// ==========================================================
	// Results
	assign sampleCode = adcOverHigh ? FS_HIGH :
		(adcOverLow ? FS_LOW : adcData);
	assign fifoInValid = (state_reg == S_CONV) && convDone;
	assign fifoInData = '{idx: idx_reg, code: sampleCode};
	assign fifoPop = regRd && (regAddr == ADDR_FIFO);

	asq_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(fifoInData),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData),
		.count(fifoCount)
	);

	// Overrun: a tick lost to a full FIFO or a busy converter.
	// Read of status clears it, but a new loss in that cycle wins.
	logic lostTick;
	assign lostTick = tick && ((state_reg == S_RUN && !fifoInReady) ||
		state_reg == S_CONV);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			overrun_reg <= 1'b0;
		end else if (lostTick) begin
			overrun_reg <= 1'b1;
		end else if (regRd && regAddr == ADDR_STATUS) begin
			overrun_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			swDone_reg <= 1'b0;
			swResult_reg <= '0;
		end else if (state_reg == S_SWCONV && convDone) begin
			swDone_reg <= 1'b1;
			swResult_reg <= sampleCode;
		end else if (regRd && regAddr == ADDR_SWRES) begin
			swDone_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Read port, data valid in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata_reg <= '0;
		end else if (regRd) begin
			rdata_reg <= '0;
			if (regAddr == ADDR_CTRL) begin
				rdata_reg[CTRL_EXTCLK] <= extClkSel_reg;
				rdata_reg[CTRL_TRIGEN] <= trigEn_reg;
				rdata_reg[CTRL_TRIGMODE+:2] <= trigMode_reg;
			end else if (regAddr == ADDR_LEN) begin
				rdata_reg[IDX_W-1:0] <= lastIdx_reg;
			end else if (regAddr == ADDR_PERIOD) begin
				rdata_reg <= period_reg;
			end else if (regAddr == ADDR_STATUS) begin
				rdata_reg[ST_RUN] <= (state_reg == S_RUN || state_reg == S_CONV);
				rdata_reg[ST_ARMED] <= (state_reg == S_ARMED);
				rdata_reg[ST_OVERRUN] <= overrun_reg;
				rdata_reg[ST_SWDONE] <= swDone_reg;
				rdata_reg[ST_FIFOCNT+:FIFO_CNT_W] <= fifoCount;
			end else if (regAddr == ADDR_FIFO) begin
				rdata_reg[FIFO_VALID_BIT] <= fifoOutValid;
				rdata_reg[SAMPLE_W-1:0] <= fifoOutData;
			end else if (regAddr == ADDR_SWRES) begin
				rdata_reg[CODE_W-1:0] <= swResult_reg;
			end else if (isListAddr(regAddr)) begin
				rdata_reg[ENTRY_W-1:0] <= list_reg[regAddr[4:2]];
			end
		end
	end

	assign regRdata = rdata_reg;
	assign sample_clock_out = sampleClkOut_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_list_wrap: assert property (
		state_reg == S_CONV && convDone && idx_reg == lastIdx_reg
		|=> idx_reg == '0)
		else $error("scan index did not wrap");
	a_list_next: assert property (
		state_reg == S_CONV && convDone && idx_reg != lastIdx_reg
		|=> idx_reg == $past(idx_reg) + 1'b1)
		else $error("scan index did not advance");
	a_req_entry: assert property (
		state_reg == S_RUN && state_next == S_CONV
		|=> convStart && convReq == $past(list_reg[idx_reg]))
		else $error("conversion request does not match entry");
	a_differential_mode_chan: assert property (
		convStart && convReq.mode == DIFFERENTIAL_MODE
		|-> !convReq.chan[IDX_W-1])
		else $error("differential channel out of range");
	a_ext_trigger_pin_default: assert property (
		$past(sys_rst) |-> trigMode_reg == EXT_TRIGGER_PIN_RISE)
		else $error("trigger mode not rising edge after reset");
	a_ext_trigger_pin_start: assert property (
		state_reg == S_ARMED && trigHit && !cmdStop |=> state_reg == S_RUN)
		else $error("qualified trigger did not start scan");
	a_period_clamp: assert property (
		periodEff >= PERIOD_MIN && periodEff <= PERIOD_MAX)
		else $error("pacing period outside span");
	a_clk_echo: assert property (
		sample_clock_out |-> !$past(extClkSel_reg) &&
		($past(state_reg) == S_RUN || $past(state_reg) == S_CONV))
		else $error("clock output driven outside internal scan");
	a_full_scale: assert property (
		fifoInValid && adcOverHigh |-> fifoInData.code == FS_HIGH)
		else $error("over range did not give full scale");
	a_conv_push: assert property (
		state_reg == S_CONV && convDone |-> fifoInValid && fifoInReady)
		else $error("scan result not stored");
	a_sw_single: assert property (
		state_reg == S_SWCONV && convDone
		|=> state_reg == S_IDLE && swDone_reg)
		else $error("software conversion not completed once");

	c_wrap: cover property (state_reg == S_CONV && convDone &&
		idx_reg == lastIdx_reg && lastIdx_reg != '0);
	c_ext_trigger_pin: cover property (state_reg == S_ARMED ##1 state_reg == S_RUN);
	c_sw: cover property (state_reg == S_SWCONV ##[1:20] swDone_reg);
	c_full: cover property (state_reg == S_RUN && !fifoInReady);

endmodule

// ### rtl/asq_pkg.sv
// Shared constants, field layouts and types of the analog scan sequencer.
// Assumes a 40 MHz system clock and a plain single-cycle register port.
package asq_pkg;

	// ==========================================================
	// Sizes
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LIST_DEPTH = 8;
	localparam int IDX_W = 3;
	localparam int CODE_W = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_CNT_W = 6;

	// ==========================================================
	// Register offsets (byte addresses, one word each)
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_LEN = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_FIFO = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_SWRES = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_LIST = 8'h20;

	// ==========================================================
	// Control word fields
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_SWCONV = 2;
	localparam int CTRL_EXTCLK = 3;
	localparam int CTRL_TRIGEN = 4;
	localparam int CTRL_TRIGMODE = 5;

	// Status word fields
	localparam int ST_RUN = 0;
	localparam int ST_ARMED = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_SWDONE = 3;
	localparam int ST_FIFOCNT = 8;
	localparam int FIFO_VALID_BIT = 31;

	// ==========================================================
	// Timing: 80 MHz period counts, advanced per 40 MHz cycle
	localparam longint TIMEBASE_HZ = 80_000_000;
	localparam longint MCLK_HZ = 40_000_000;
	localparam longint RATE_MAX_HZ = 250_000;
	localparam longint RATE_MIN_MHZ = 19;
	localparam logic [32:0] TB_PER_MCLK = 33'(TIMEBASE_HZ / MCLK_HZ);
	localparam logic [31:0] PERIOD_MIN = 32'(TIMEBASE_HZ / RATE_MAX_HZ);
	localparam logic [31:0] PERIOD_MAX =
		32'(TIMEBASE_HZ * 1000 / RATE_MIN_MHZ);

	// Full-scale codes, offset binary
	localparam logic [CODE_W-1:0] FS_HIGH = 16'hFFFF;
	localparam logic [CODE_W-1:0] FS_LOW = 16'h0000;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		EXT_TRIGGER_PIN_RISE,
		EXT_TRIGGER_PIN_FALL,
		EXT_TRIGGER_PIN_HIGH,
		EXT_TRIGGER_PIN_LOW
	} asq_ext_trigger_pin_t;

	typedef enum logic [1:0] {
		RANGE_BIPOLAR_10V,
		RANGE_BIPOLAR_5V,
		RANGE_BIPOLAR_2V,
		RANGE_BIPOLAR_1V
	} asq_range_t;

	typedef enum logic {
		SINGLE_ENDED_MODE,
		DIFFERENTIAL_MODE
	} asq_mode_t;

	typedef struct packed {
		asq_range_t range;
		asq_mode_t mode;
		logic [IDX_W-1:0] chan;
	} asq_entry_t;

	typedef struct packed {
		logic [IDX_W-1:0] idx;
		logic [CODE_W-1:0] code;
	} asq_sample_t;

	localparam int SAMPLE_W = $bits(asq_sample_t);
	localparam int ENTRY_W = $bits(asq_entry_t);

endpackage

// ### rtl/asq_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module asq_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 32
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic [$clog2(DEPTH):0] count
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr_reg;
	logic [PW-1:0] rdPtr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;

	assign inReady = (count_reg != (PW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign outData = mem[rdPtr_reg];
	assign count = count_reg;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule

// ### test/asq_adc_model.sv
// Converter model for the scan sequencer bench.
// Assumes one conversion outstanding at a time, all on mclk.
`timescale 1ns/1ps
// ==========================================================
// Converter
module asq_adc_model (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic convStart,
	input wire asq_pkg::asq_entry_t convReq,
	input wire logic [7:0] latency,
	input wire logic [1:0] overSel,
	output logic convDone,
	output logic [asq_pkg::CODE_W-1:0] adcData,
	output logic adcOverHigh,
	output logic adcOverLow
);
	import asq_pkg::*;
	logic busy;
	logic [7:0] waitCnt;
	asq_entry_t req;
	always @(posedge mclk) begin
		convDone <= 1'b0;
		// Outside an answer the lines toggle, showing the last code every other cycle
		adcData <= ~adcData;
		adcOverHigh <= ~adcOverHigh;
		adcOverLow <= ~adcOverLow;
		if (sys_rst) begin
			busy <= 1'b0;
			waitCnt <= 8'h00;
			req <= '0;
			adcData <= 16'h0000;
			adcOverHigh <= 1'b0;
			adcOverLow <= 1'b0;
		end else if (convStart) begin
			busy <= 1'b1;
			waitCnt <= latency;
			req <= convReq;
		end else if (busy && waitCnt <= 8'h01) begin
			// Code names the request so the bench can trace each sample
			busy <= 1'b0;
			convDone <= 1'b1;
			adcData <= {10'h2A5, req};
			adcOverHigh <= overSel[0];
			adcOverLow <= overSel[1];
		end else if (busy) begin
			waitCnt <= waitCnt - 8'h01;
		end
	end
endmodule

// ### test/analog_scan_sequencer_test.sv
// Self-checking bench for the scan sequencer top.
// Assumes the converter model and a 40 MHz clock.
`timescale 1ns/1ps
module analog_scan_sequencer_test;
	import asq_pkg::*;
	logic mclk, sys_rst, regWr, regRd, extClk, trigPin, sampleOut;
	logic convStart, convDone, adcOverHigh, adcOverLow;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWdata, regRdata, rv;
	logic [CODE_W-1:0] adcData;
	logic [7:0] latency;
	logic [1:0] overSel;
	asq_entry_t convReq;
	int n_errors, comparisons, cycles, gap;
	logic [5:0] list [0:4] = '{6'h15, 6'h01, 6'h33, 6'h35, 6'h2E};

	asq_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .ext_sample_clock_in(extClk),
		.ext_trigger_pin(trigPin), .sample_clock_out(sampleOut),
		.convStart(convStart), .convReq(convReq), .convDone(convDone),
		.adcData(adcData), .adcOverHigh(adcOverHigh),
		.adcOverLow(adcOverLow));
	asq_adc_model i_adc (.mclk(mclk), .sys_rst(sys_rst),
		.convStart(convStart), .convReq(convReq), .latency(latency),
		.overSel(overSel), .convDone(convDone), .adcData(adcData),
		.adcOverHigh(adcOverHigh), .adcOverLow(adcOverLow));

	// ==========================================================
	// Clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end

	// ==========================================================
	// Tasks
	task automatic close_out();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	// Returns the number of edges waited up to the start pulse
	task automatic wait_conv(int limit, output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (convStart !== 1'b1 && n < limit);
		if (convStart !== 1'b1) chk("conv start", 0, 1);
	endtask
	task automatic drain(int n, int len);
		logic [31:0] d;
		for (int k = 0; k < n; k++) begin
			rd(ADDR_FIFO, d);
			chk("fifo word", d, {1'b1, 12'h000, 3'(k % len), 10'h2A5,
				list[k % len]});
		end
		rd(ADDR_FIFO, d);
		chk("fifo empty", 32'(d[FIFO_VALID_BIT]), 0);
	endtask

	// ==========================================================
	// Tests
	initial begin
		sys_rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = '0;
		regWdata = '0;
		extClk = 1'b0;
		trigPin = 1'b0;
		latency = 8'd3;
		overSel = 2'b00;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(ADDR_STATUS, rv);
		chk("status", rv, 32'h0000_0000);
		rd(ADDR_PERIOD, rv);
		chk("period", rv, 32'h0000_0140);
		rd(ADDR_CTRL, rv);
		chk("ctrl default", rv, 32'h0000_0000);
		rd(8'h18, rv);
		chk("unmapped", rv, 32'h0000_0000);
		for (int i = 0; i < 5; i++) wr(ADDR_LIST + 8'(4 * i), 32'(list[i]));
		wr(ADDR_LEN, 32'h0000_0003);
		// Differential entry loses the upper channel bit
		list[4] = 6'h2A;
		for (int i = 0; i < 5; i++) begin
			rd(ADDR_LIST + 8'(4 * i), rv);
			chk("entry", rv, 32'(list[i]));
		end
		// Single conversions: slow answer, over high, over low
		for (int k = 0; k < 3; k++) begin
			overSel <= 2'(k);
			latency <= (k == 0) ? 8'd40 : 8'd3;
			wr(ADDR_CTRL, 32'h0000_0004);
			// The start pulse rises at the edge that takes the write
			#1 chk("sw start", 32'(convStart), 1);
			chk("sw request", 32'(convReq), 32'(list[0]));
			rv = '0;
			for (int t = 0; t < 60 && rv[ST_SWDONE] !== 1'b1; t++)
				rd(ADDR_STATUS, rv);
			chk("sw done", 32'(rv[ST_SWDONE]), 1);
			rd(ADDR_SWRES, rv);
			chk("sw result", rv, (k == 0) ? {16'h0, 10'h2A5, list[0]} :
				((k == 1) ? 32'h0000_FFFF : 32'h0));
		end
		rd(ADDR_STATUS, rv);
		chk("sw done clear", rv, 32'h0000_0000);
		// Internal pacing with a period below the floor
		overSel <= 2'b00;
		wr(ADDR_PERIOD, 32'h0000_000A);
		wr(ADDR_CTRL, 32'h0000_0001);
		for (int k = 0; k < 6; k++) begin
			wait_conv(400, gap);
			if (k > 0) chk("tick gap", gap, 160);
			chk("scan entry", 32'(convReq), 32'(list[k % 4]));
			chk("clock out", 32'(sampleOut), 1);
		end
		wr(ADDR_CTRL, 32'h0000_0002);
		repeat (10) @(posedge mclk);
		rd(ADDR_PERIOD, rv);
		chk("period raw", rv, 32'h0000_000A);
		drain(6, 4);
		// External pacing keeps the clock output quiet
		wr(ADDR_CTRL, 32'h0000_0009);
		for (int k = 0; k < 3; k++) begin
			repeat (30) @(posedge mclk);
			extClk <= 1'b1;
			wait_conv(20, gap);
			chk("ext entry", 32'(convReq), 32'(list[k]));
			chk("ext clock out", 32'(sampleOut), 0);
			repeat (20) @(posedge mclk);
			extClk <= 1'b0;
		end
		wr(ADDR_CTRL, 32'h0000_000A);
		repeat (10) @(posedge mclk);
		drain(3, 4);
		// Each trigger mode: armed while idle, runs once active
		for (int m = 0; m < 4; m++) begin
			trigPin <= (m == 1 || m == 3);
			repeat (8) @(posedge mclk);
			wr(ADDR_CTRL, 32'h0000_0011 | (32'(m) << 5));
			repeat (30) @(posedge mclk);
			rd(ADDR_STATUS, rv);
			chk("armed", rv, 32'h0000_0002);
			trigPin <= !(m == 1 || m == 3);
			wait_conv(400, gap);
			chk("ext_trigger_pin entry", 32'(convReq), 32'(list[0]));
			wr(ADDR_CTRL, 32'h0000_0012 | (32'(m) << 5));
			repeat (10) @(posedge mclk);
			repeat (6) rd(ADDR_FIFO, rv);
		end
		// Buffer fills until ticks are dropped
		wr(ADDR_LEN, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0001);
		repeat (34 * 160 + 100) @(posedge mclk);
		wr(ADDR_CTRL, 32'h0000_0002);
		repeat (10) @(posedge mclk);
		rd(ADDR_STATUS, rv);
		chk("full", rv, 32'h0000_2004);
		rd(ADDR_STATUS, rv);
		chk("overrun clear", rv, 32'h0000_2000);
		drain(32, 1);
		rd(ADDR_STATUS, rv);
		chk("empty", rv, 32'h0000_0000);
		close_out();
	end
endmodule
